// *** abo_core.sv ***
`timescale 1ns/1ns
`default_nettype none
package abo_pkg;
	localparam int          ABO_BUS_AW     = 10;
	localparam int          ABO_DW         = 8;
	localparam int          ABO_FILE_DEPTH = 128;
	// byte addresses of the register map
	localparam logic [9:0]  ABO_CMD_OFS    = 10'h000;
	localparam logic [9:0]  ABO_ACC_OFS    = 10'h004;
	localparam logic [9:0]  ABO_STAT_OFS   = 10'h008;
	localparam logic [9:0]  ABO_FILE_BASE  = 10'h200;
	// status bit positions
	localparam int          ABO_ST_OVF     = 0;
	localparam int          ABO_ST_HALF    = 1;
	localparam int          ABO_ST_NULL    = 2;
	localparam int          ABO_ST_SKIP    = 3;
	localparam int          ABO_ST_DISC    = 4;
	// values after reset
	localparam logic [7:0]  ABO_ACC_RST    = 8'h00;
	localparam logic [2:0]  ABO_FLAG_RST   = 3'h0;
	// instruction codes in the command word
	localparam logic [3:0]  ABO_OP_NOP     = 4'h0;
	localparam logic [3:0]  ABO_OP_ADD_IMM = 4'h1;
	localparam logic [3:0]  ABO_OP_ADD_REG = 4'h2;
	localparam logic [3:0]  ABO_OP_AND_IMM = 4'h3;
	localparam logic [3:0]  ABO_OP_AND_REG = 4'h4;
	localparam logic [3:0]  ABO_OP_BCLR    = 4'h5;
	localparam logic [3:0]  ABO_OP_BSET    = 4'h6;
	localparam logic [3:0]  ABO_OP_TSZ     = 4'h7;
	localparam logic [3:0]  ABO_OP_TSO     = 4'h8;
	localparam logic        ABO_DEST_ACC   = 1'b0;

	// command word layout, bits 15:0 of the write data
	typedef struct packed {
		logic [3:0] op;
		logic [2:0] bit_sel;
		logic       dest;
		logic [7:0] operand;
	} abo_cmd_t;

	typedef struct packed {
		logic result_null_flag;
		logic half_carry_flag;
		logic result_ovf_bit;
	} abo_flags_t;

	typedef enum logic [1:0] {
		ABO_IDLE,
		ABO_FETCH,
		ABO_EXEC,
		ABO_DONE
	} abo_state_t;

	typedef struct packed {
		abo_state_t  state;
		abo_cmd_t    cmd;
		logic [7:0]  acc;
		abo_flags_t  flags;
		logic        skip;
		logic        discarded;
		logic        rd_wait;
		logic        rd_file;
		logic [31:0] rdata;
	} abo_regs_t;
endpackage : abo_pkg

module abo_core
	import abo_pkg::*;
#(
	parameter int FILE_DEPTH = ABO_FILE_DEPTH
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_b_i,
	input  wire logic [ABO_BUS_AW-1:0] avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	input  wire logic [3:0]            avs_byteenable,
	output logic      [31:0]           avs_readdata,
	output logic                       avs_waitrequest
);
	localparam int FAW = $clog2(FILE_DEPTH);

	if (FILE_DEPTH < 2 || FILE_DEPTH > ABO_FILE_DEPTH) begin : g_chk
		$error("abo_core: file depth must be 2 to 128");
	end

	abo_regs_t              r_q;
	abo_regs_t              r_d;
	logic                   mem_we;
	logic [FAW-1:0]         mem_addr;
	logic [ABO_DW-1:0]      mem_wdata;
	logic [ABO_DW-1:0]      mem_rdata;

	// sum with carry out of bit 7 and of bit 3: {ovf, half, sum}
	function automatic logic [9:0] abo_add(input logic [7:0] a,
	                                       input logic [7:0] b);
		logic [8:0] full;
		logic [4:0] low;
		full = {1'b0, a} + {1'b0, b};
		low  = {1'b0, a[3:0]} + {1'b0, b[3:0]};
		return {full[8], low[4], full[7:0]};
	endfunction : abo_add

	function automatic logic abo_is_null(input logic [7:0] v);
		return v == 8'h00;
	endfunction : abo_is_null

	// upper bound kept in eleven bits: a full-depth window ends at 0x400,
	// which a ten-bit sum would wrap to zero and so match no address
	function automatic logic abo_in_file(input logic [ABO_BUS_AW-1:0] a);
		return a >= ABO_FILE_BASE &&
		       11'(a) < 11'(ABO_FILE_BASE) + 11'(4 * FILE_DEPTH);
	endfunction : abo_in_file

	abo_file_mem #(
		.W     (ABO_DW),
		.DEPTH (FILE_DEPTH),
		.AW    (FAW)
	) u_mem (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.we_i    (mem_we),
		.addr_i  (mem_addr),
		.wdata_i (mem_wdata),
		.rdata_o (mem_rdata)
	);

	// a file read answers straight from the store's output register
	assign avs_readdata = r_q.rd_file ? {24'h000000, mem_rdata} : r_q.rdata;

	// bus slave and instruction sequencer in one next-state process
	always_comb begin
		logic [7:0] opb;
		logic [9:0] sum;
		logic [7:0] conj;
		logic [7:0] mask;
		opb             = r_q.cmd.operand;
		sum             = 10'h000;
		conj            = 8'h00;
		mask            = 8'h00;
		r_d             = r_q;
		mem_we          = 1'b0;
		mem_addr        = r_q.cmd.operand[FAW-1:0];
		mem_wdata       = 8'h00;
		avs_waitrequest = 1'b1;
		case (r_q.state)
			ABO_IDLE: begin
				if (avs_read) begin
					mem_addr = avs_address[FAW+1:2];
					if (r_q.rd_wait) begin
						// second cycle: answer stands on the outputs now
						avs_waitrequest = 1'b0;
						r_d.rd_wait     = 1'b0;
						r_d.rd_file     = 1'b0;
					end else begin
						r_d.rd_wait = 1'b1;
						r_d.rd_file = abo_in_file(avs_address);
						case (avs_address)
							ABO_ACC_OFS:  r_d.rdata = {24'h000000, r_q.acc};
							ABO_STAT_OFS: r_d.rdata = {27'h0000000,
							                           r_q.discarded, r_q.skip,
							                           r_q.flags};
							default:      r_d.rdata = 32'h00000000;
						endcase
					end
				end else if (avs_write) begin
					if (avs_address == ABO_CMD_OFS) begin
						// held in wait until the instruction has finished
						r_d.cmd   = abo_cmd_t'(avs_writedata[15:0]);
						r_d.state = ABO_FETCH;
					end else begin
						avs_waitrequest = 1'b0;
						mem_addr        = avs_address[FAW+1:2];
						mem_wdata       = avs_writedata[7:0];
						if (avs_byteenable[0]) begin
							mem_we = abo_in_file(avs_address);
							if (avs_address == ABO_ACC_OFS) begin
								r_d.acc = avs_writedata[7:0];
							end
							if (avs_address == ABO_STAT_OFS) begin
								r_d.flags = abo_flags_t'(avs_writedata[2:0]);
							end
						end
					end
				end
			end
			ABO_FETCH: begin
				// store read issued at the operand address
				r_d.state = ABO_EXEC;
			end
			ABO_EXEC: begin
				r_d.state = ABO_DONE;
				if (r_q.cmd.op == ABO_OP_ADD_REG || r_q.cmd.op == ABO_OP_AND_REG) begin
					opb = mem_rdata;
				end
				sum       = abo_add(r_q.acc, opb);
				conj      = r_q.acc & opb;
				mask      = 8'h01 << r_q.cmd.bit_sel;
				mem_wdata = sum[7:0];
				if (r_q.skip) begin
					// instruction after a taken test runs as a no-op
					r_d.skip      = 1'b0;
					r_d.discarded = 1'b1;
				end else begin
					r_d.discarded = 1'b0;
					case (r_q.cmd.op)
						ABO_OP_ADD_IMM: begin
							r_d.acc                        = sum[7:0];
							r_d.flags.result_ovf_bit       = sum[9];
							r_d.flags.half_carry_flag      = sum[8];
							r_d.flags.result_null_flag     = abo_is_null(sum[7:0]);
						end
						ABO_OP_ADD_REG: begin
							r_d.flags.result_ovf_bit       = sum[9];
							r_d.flags.half_carry_flag      = sum[8];
							r_d.flags.result_null_flag     = abo_is_null(sum[7:0]);
							if (r_q.cmd.dest == ABO_DEST_ACC) begin
								r_d.acc = sum[7:0];
							end else begin
								mem_we = 1'b1;
							end
						end
						ABO_OP_AND_IMM: begin
							r_d.acc                    = conj;
							r_d.flags.result_null_flag = abo_is_null(conj);
						end
						ABO_OP_AND_REG: begin
							r_d.flags.result_null_flag = abo_is_null(conj);
							mem_wdata                  = conj;
							if (r_q.cmd.dest == ABO_DEST_ACC) begin
								r_d.acc = conj;
							end else begin
								mem_we = 1'b1;
							end
						end
						ABO_OP_BCLR: begin
							mem_we    = 1'b1;
							mem_wdata = mem_rdata & ~mask;
						end
						ABO_OP_BSET: begin
							mem_we    = 1'b1;
							mem_wdata = mem_rdata | mask;
						end
						ABO_OP_TSZ: begin
							r_d.skip = ~mem_rdata[r_q.cmd.bit_sel];
						end
						ABO_OP_TSO: begin
							r_d.skip = mem_rdata[r_q.cmd.bit_sel];
						end
						default: begin
							// no-op and unknown codes change nothing
						end
					endcase
				end
			end
			ABO_DONE: begin
				avs_waitrequest = 1'b0;
				r_d.state       = ABO_IDLE;
			end
			default: begin
				r_d.state = ABO_IDLE;
			end
		endcase
	end

	// all control state registered together
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			r_q <= '{state: ABO_IDLE, cmd: '0, acc: ABO_ACC_RST,
			         flags: abo_flags_t'(ABO_FLAG_RST), skip: 1'b0,
			         discarded: 1'b0, rd_wait: 1'b0, rd_file: 1'b0,
			         rdata: 32'h00000000};
		end else begin
			r_q <= r_d;
		end
	end
endmodule : abo_core
`default_nettype wire

// *** abo_file_mem.sv ***
`timescale 1ns/1ns
`default_nettype none
// single-port file register store; read data come out of a register one
// cycle after the address is presented
module abo_file_mem #(
	parameter int W     = 8,
	parameter int DEPTH = 128,
	parameter int AW    = 7
) (
	input  wire logic          clk_i,
	input  wire logic          rst_b_i,
	input  wire logic          we_i,
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [W-1:0]  wdata_i,
	output logic      [W-1:0]  rdata_o
);
	logic [W-1:0] mem [DEPTH];
	logic [W-1:0] rdata_q;

	if (DEPTH > (1 << AW) || DEPTH < 2) begin : g_chk
		$error("abo_file_mem: depth does not fit the address width");
	end

	// array has no reset: contents are undefined until software writes them
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[addr_i] <= wdata_i;
		end
	end

	// read-before-write: a read in a write cycle returns the old value
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= mem[addr_i];
		end
	end

	assign rdata_o = rdata_q;
endmodule : abo_file_mem
`default_nettype wire

// *** abo_core_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module abo_core_assertions
	import abo_pkg::*;
(
	input wire logic                  clk_i,
	input wire logic                  rst_b_i,
	input wire logic [ABO_BUS_AW-1:0] avs_address,
	input wire logic                  avs_read,
	input wire logic                  avs_write,
	input wire logic [31:0]           avs_writedata,
	input wire logic [3:0]            avs_byteenable,
	input wire logic [31:0]           avs_readdata,
	input wire logic                  avs_waitrequest
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// decoded bus events; a read completes when waitrequest drops
	wire logic cmd_w = avs_write && avs_address == ABO_CMD_OFS;
	wire logic rd_ok = avs_read && !avs_waitrequest;
	wire logic acc_w = avs_write && avs_address == ABO_ACC_OFS;
	wire logic st_w  = avs_write && avs_address == ABO_STAT_OFS;

	a_cmd_wait_three: assert property (cmd_w && !$past(cmd_w) |->
		avs_waitrequest [*3] ##1 !avs_waitrequest) else $error("cmd ack late");
	a_read_one_wait: assert property (avs_read && !$past(avs_read) |->
		avs_waitrequest ##1 !avs_waitrequest) else $error("read ack late");
	a_write_no_wait: assert property (avs_write && !cmd_w |->
		!avs_waitrequest) else $error("plain write stalled");
	a_upper_zero: assert property (rd_ok |->
		avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
	a_cmd_read_zero: assert property (rd_ok && avs_address == ABO_CMD_OFS |->
		avs_readdata == 32'h0) else $error("command word readable");
	a_unmapped_zero: assert property (rd_ok && avs_address == 10'h00c |->
		avs_readdata == 32'h0) else $error("unmapped read not zero");
	// a lane-0 write must be what the next read of that place returns
	a_acc_readback: assert property (acc_w && avs_byteenable[0] ##1
		!avs_write ##1 avs_read && avs_address == ABO_ACC_OFS [*2] |->
		avs_readdata[7:0] == $past(avs_writedata[7:0], 3))
		else $error("accumulator readback wrong");
	a_flag_readback: assert property (st_w && avs_byteenable[0] ##1
		!avs_write ##1 avs_read && avs_address == ABO_STAT_OFS [*2] |->
		avs_readdata[2:0] == $past(avs_writedata[2:0], 3))
		else $error("flag readback wrong");
endmodule : abo_core_assertions
`default_nettype wire

// *** abo_core_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module abo_core_test
	import abo_pkg::*;
;
	logic                  clk_i;
	logic                  rst_b_i;
	logic [ABO_BUS_AW-1:0] avs_address;
	logic                  avs_read;
	logic                  avs_write;
	logic [31:0]           avs_writedata;
	logic [3:0]            avs_byteenable;
	logic [31:0]           avs_readdata;
	logic                  avs_waitrequest;
	int                    failures = 0;
	int                    n_checks = 0;
	// reference copy: accumulator, file, status {disc,skip,null,half,ovf}
	logic [7:0]            ma;
	logic [7:0]            mf [128];
	logic [4:0]            ms;
	logic [31:0]           q;

	abo_core i_abo_core (.clk_i, .rst_b_i, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest);

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk

	task automatic results();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results

	// one transfer held until waitrequest is seen low; an idle cycle after
	// keeps release and the next request out of the same time step
	task automatic bus(input logic w, input logic [9:0] a,
		input logic [31:0] d, input logic [3:0] be);
		int n;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= w;
		avs_read <= !w;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50)
			failures++;
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_i);
	endtask : bus

	// issue one command and step the reference copy the same way
	task automatic cmd(input logic [15:0] c);
		logic [3:0] op;
		logic [7:0] o;
		logic [8:0] s;
		logic [6:0] f;
		op = c[15:12];
		f = c[6:0];
		o = (op == ABO_OP_ADD_IMM || op == ABO_OP_AND_IMM) ? c[7:0] : mf[f];
		bus(1'b1, ABO_CMD_OFS, {16'h0, c}, 4'hf);
		ms[4] = ms[3];
		s = {1'b0, ma} + {1'b0, o};
		if (ms[3])
			ms[3] = 1'b0;
		else case (op)
		ABO_OP_ADD_IMM, ABO_OP_ADD_REG: begin
			ms[2:0] = {s[7:0] == 8'h0, {1'b0, ma[3:0]} + o[3:0] > 5'hf, s[8]};
			if (op == ABO_OP_ADD_IMM || !c[8]) ma = s[7:0];
			else mf[f] = s[7:0];
		end
		ABO_OP_AND_IMM, ABO_OP_AND_REG: begin
			ms[2] = (ma & o) == 8'h0;
			if (op == ABO_OP_AND_IMM || !c[8]) ma = ma & o;
			else mf[f] = ma & o;
		end
		ABO_OP_BCLR: mf[f][c[11:9]] = 1'b0;
		ABO_OP_BSET: mf[f][c[11:9]] = 1'b1;
		ABO_OP_TSZ: ms[3] = !o[c[11:9]];
		ABO_OP_TSO: ms[3] = o[c[11:9]];
		default: ;
		endcase
	endtask : cmd

	// watchdog: the run needs well under 10000 cycles
	initial begin
		#(50 * 20000);
		failures++;
		results();
	end

	initial begin
		// corner cases {acc, command}: full carry to zero, and to zero, half
		logic [23:0] corner [3];
		logic [15:0] c;
		int          j;
		corner = '{24'h0f10f1, 24'hf0300f, 24'h081008};
		rst_b_i = 1'b0;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		avs_byteenable = 4'hf;
		void'($urandom(27));
		repeat (8) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		bus(1'b0, ABO_STAT_OFS, 32'h0, 4'hf);
		chk(q, 32'h0);
		bus(1'b0, 10'h00c, 32'h0, 4'hf);
		bus(1'b0, ABO_CMD_OFS, 32'h0, 4'hf);
		// lane 0 off must leave the accumulator alone
		bus(1'b1, ABO_ACC_OFS, 32'h5a, 4'he);
		bus(1'b0, ABO_ACC_OFS, 32'h0, 4'hf);
		chk(q, {24'h0, ABO_ACC_RST});
		// lane 0 on: the write lands and the next read returns it
		bus(1'b1, ABO_ACC_OFS, 32'h3c, 4'hf);
		bus(1'b0, ABO_ACC_OFS, 32'h0, 4'hf);
		chk(q, 32'h0000003c);
		bus(1'b1, ABO_STAT_OFS, 32'h7, 4'hf);
		bus(1'b0, ABO_STAT_OFS, 32'h0, 4'hf);
		ms = 5'h07;
		for (int i = 0; i < 8; i++) begin
			j = (i == 7) ? 127 : i;
			mf[j] = 8'($urandom);
			bus(1'b1, ABO_FILE_BASE + 10'(4 * j), {24'h0, mf[j]}, 4'hf);
		end
		for (int i = 0; i < 303; i++) begin
			j = $urandom_range(0, 7);
			j = (j == 7) ? 127 : j;
			c = {4'($urandom_range(0, 9)), 4'($urandom), 8'($urandom)};
			if (c[15:12] != ABO_OP_ADD_IMM && c[15:12] != ABO_OP_AND_IMM)
				c[7:0] = 8'(j);
			if (i < 3 || $urandom_range(0, 3) == 0) begin
				ma = (i < 3) ? corner[i][23:16] : 8'($urandom);
				bus(1'b1, ABO_ACC_OFS, {24'h0, ma}, 4'hf);
			end
			if (i < 3)
				c = corner[i][15:0];
			if (i < 3)
				j = 0;
			cmd(c);
			bus(1'b0, ABO_ACC_OFS, 32'h0, 4'hf);
			chk(q, {24'h0, ma});
			bus(1'b0, ABO_STAT_OFS, 32'h0, 4'hf);
			chk(q, {27'h0, ms});
			bus(1'b0, ABO_FILE_BASE + 10'(4 * j), 32'h0, 4'hf);
			chk(q, {24'h0, mf[j]});
		end
		results();
	end
endmodule : abo_core_test

bind abo_core abo_core_assertions i_abo_core_assertions (.clk_i, .rst_b_i,
	.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
	.avs_readdata, .avs_waitrequest);
`default_nettype wire
